// ---- rtl/vcw_top.sv ----
// Capture start control, acquisition window selection, trigger line and register slave
`default_nettype none
module vcw_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic nv_valid,
   input wire logic [31:0] nv_data,
   output logic nv_req,
   output logic [2:0] nv_addr,
   input wire logic pix_line_en,
   input wire logic pix_frame_en,
   input wire logic pix_field_odd,
   input wire logic [31:0] pix_data,
   output logic [31:0] out_data,
   output logic out_valid,
   output logic out_frame_end,
   input wire logic external_trigger_line_in,
   output logic external_trigger_line_out,
   output logic external_trigger_line_oe,
   output logic capture_busy
);
   logic [31:0] reg_ctrl;
   logic [31:0] reg_external_trigger_line;
   logic [31:0] reg_count;
   logic [31:0] reg_win_pix;
   logic [31:0] reg_win_lin;
   logic [31:0] reg_roi_pix;
   logic [31:0] reg_roi_lin;
   logic [31:0] reg_decim;
   logic [15:0] done_cnt;
   logic [2:0] nv_idx;
   logic external_trigger_line_q;
   logic line_q;
   logic frame_q;
   logic started;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic rd_pend;
   logic [7:0] rd_addr;
   vcw_pkg::vcw_state_t state;
   vcw_pkg::vcw_state_t next_state;

   // Bus address phase decode
   wire addr_ph = hsel && hready && htrans[1];
   wire wr_now = wr_pend;
   wire external_trigger_line_rise = external_trigger_line_in && !external_trigger_line_q;
   wire external_trigger_line_fall = !external_trigger_line_in && external_trigger_line_q;
   wire external_trigger_line_edge = reg_external_trigger_line[vcw_pkg::EXTERNAL_TRIGGER_LINE_EDGE_FALL] ? external_trigger_line_fall : external_trigger_line_rise;
   wire line_start = pix_line_en && !line_q;
   wire frame_start = pix_frame_en && !frame_q;
   wire frame_end = !pix_frame_en && frame_q;
   wire sw_start = wr_now && wr_addr == vcw_pkg::ADDR_CTRL && hwdata[vcw_pkg::CTRL_START];
   wire sw_stop = wr_now && wr_addr == vcw_pkg::ADDR_CTRL && hwdata[vcw_pkg::CTRL_STOP];
   wire field_sel = reg_ctrl[vcw_pkg::CTRL_FRAME_MODE] && reg_ctrl[vcw_pkg::CTRL_FIELD_SEL_EN];
   wire field_ok = pix_field_odd == reg_ctrl[vcw_pkg::CTRL_FIELD_ODD];
   wire count_done = ({done_cnt, 16'h0000} >> 16) + 32'h1 >= reg_count;
   wire pix_keep;
   wire lin_keep;
   wire running = state == vcw_pkg::VCW_RUN;
   // Includes the frame start cycle so the first pixel of a capture is kept
   wire capture_on = next_state == vcw_pkg::VCW_RUN;
   wire [7:0] ev_sel = reg_external_trigger_line[vcw_pkg::EXTERNAL_TRIGGER_LINE_EVENT_LSB +: 8];
   wire ev_sig = ev_sel == 8'h00 ? running :
                 ev_sel == 8'h01 ? frame_start && running :
                 ev_sel == 8'h02 ? out_frame_end : line_start && running;
   wire external_trigger_line_lvl = reg_external_trigger_line[vcw_pkg::EXTERNAL_TRIGGER_LINE_EVENT_EN] ? ev_sig : reg_external_trigger_line[vcw_pkg::EXTERNAL_TRIGGER_LINE_LEVEL];

   vcw_axis_sel u_pix (
      .clk(clk),
      .rst_b(rst_b),
      .restart(line_start),
      .step(pix_line_en && !line_start),
      .win_range(reg_win_pix),
      .roi_range(reg_roi_pix),
      .roi_en(reg_ctrl[vcw_pkg::CTRL_ROI_EN]),
      .decim(reg_decim[vcw_pkg::HOR_DEC_LSB +: 2]),
      .keep(pix_keep)
   );
   vcw_axis_sel u_lin (
      .clk(clk),
      .rst_b(rst_b),
      .restart(frame_start),
      .step(line_start && !frame_start),
      .win_range(reg_win_lin),
      .roi_range(reg_roi_lin),
      .roi_en(reg_ctrl[vcw_pkg::CTRL_ROI_EN]),
      .decim(reg_decim[vcw_pkg::VER_DEC_LSB +: 2]),
      .keep(lin_keep)
   );

   // Start state machine
   always_comb begin
      next_state = state;
      case (state)
         vcw_pkg::VCW_LOAD: begin
            if (nv_valid && nv_idx == 3'h7) begin
               next_state = vcw_pkg::VCW_IDLE;
            end
         end
         vcw_pkg::VCW_IDLE: begin
            if (sw_start) begin
               next_state = vcw_pkg::VCW_ARMED;
            end
         end
         vcw_pkg::VCW_ARMED: begin
            if (sw_stop) begin
               next_state = vcw_pkg::VCW_IDLE;
            end else if (!reg_ctrl[vcw_pkg::CTRL_EXTERNAL_TRIGGER_LINE_EN] || external_trigger_line_edge) begin
               next_state = vcw_pkg::VCW_WAIT_FIELD;
            end
         end
         vcw_pkg::VCW_WAIT_FIELD: begin
            if (sw_stop) begin
               next_state = vcw_pkg::VCW_IDLE;
            end else if (frame_start && (!field_sel || field_ok)) begin
               next_state = vcw_pkg::VCW_RUN;
            end
         end
         vcw_pkg::VCW_RUN: begin
            if (sw_stop || (frame_end && count_done)) begin
               next_state = vcw_pkg::VCW_IDLE;
            end
         end
         default: begin
            next_state = vcw_pkg::VCW_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= vcw_pkg::VCW_LOAD;
      end else begin
         state <= next_state;
      end
   end

   // Frame counting within an acquisition
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         done_cnt <= 16'h0000;
      end else if (state != vcw_pkg::VCW_RUN) begin
         done_cnt <= 16'h0000;
      end else if (frame_end) begin
         done_cnt <= done_cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         external_trigger_line_q <= 1'b0;
         line_q <= 1'b0;
         frame_q <= 1'b0;
         started <= 1'b0;
      end else begin
         external_trigger_line_q <= external_trigger_line_in;
         line_q <= pix_line_en;
         frame_q <= pix_frame_en;
         started <= next_state == vcw_pkg::VCW_RUN;
      end
   end

   // Pixel output path
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_data <= 32'h0000_0000;
         out_valid <= 1'b0;
         out_frame_end <= 1'b0;
      end else begin
         out_valid <= capture_on && pix_line_en && pix_frame_en && pix_keep && lin_keep;
         out_data <= pix_data;
         out_frame_end <= running && frame_end;
      end
   end

   // Trigger line drive
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         external_trigger_line_out <= 1'b0;
         external_trigger_line_oe <= 1'b0;
      end else begin
         external_trigger_line_oe <= reg_external_trigger_line[vcw_pkg::EXTERNAL_TRIGGER_LINE_DRIVE_EN];
         external_trigger_line_out <= external_trigger_line_lvl ^ reg_external_trigger_line[vcw_pkg::EXTERNAL_TRIGGER_LINE_INVERT];
      end
   end

   // Configuration load from nonvolatile storage
   assign nv_req = state == vcw_pkg::VCW_LOAD;
   assign nv_addr = nv_idx;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         nv_idx <= 3'h0;
      end else if (nv_req && nv_valid) begin
         nv_idx <= nv_idx + 3'h1;
      end
   end

   // Bus data phase tracking
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         wr_addr <= 8'h00;
         rd_addr <= 8'h00;
      end else begin
         wr_pend <= addr_ph && hwrite;
         rd_pend <= addr_ph && !hwrite;
         wr_addr <= addr_ph ? haddr[7:0] : wr_addr;
         rd_addr <= addr_ph ? haddr[7:0] : rd_addr;
      end
   end

   // Register writes: loader fills in order, then software owns them
   wire ld_wr = nv_req && nv_valid;
   function automatic logic hit(input logic [7:0] a, input logic [2:0] idx, input logic [7:0] off,
                                input logic [2:0] nvi);
      hit = ld_wr ? (idx == nvi) : (wr_pend && a == off);
   endfunction
   wire [31:0] wval = ld_wr ? nv_data : hwdata;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_ctrl <= vcw_pkg::RST_CTRL;
         reg_external_trigger_line <= vcw_pkg::RST_EXTERNAL_TRIGGER_LINE;
         reg_count <= vcw_pkg::RST_COUNT;
         reg_win_pix <= vcw_pkg::RST_RANGE;
         reg_win_lin <= vcw_pkg::RST_RANGE;
         reg_roi_pix <= vcw_pkg::RST_RANGE;
         reg_roi_lin <= vcw_pkg::RST_RANGE;
         reg_decim <= vcw_pkg::RST_DECIM;
      end else begin
         if (hit(wr_addr, nv_idx, vcw_pkg::ADDR_CTRL, 3'h0)) reg_ctrl <= wval & 32'hFFFF_FFFC;
         if (hit(wr_addr, nv_idx, vcw_pkg::ADDR_EXTERNAL_TRIGGER_LINE, 3'h1)) reg_external_trigger_line <= wval;
         if (hit(wr_addr, nv_idx, vcw_pkg::ADDR_COUNT, 3'h2)) reg_count <= wval;
         if (hit(wr_addr, nv_idx, vcw_pkg::ADDR_WIN_PIX, 3'h3)) reg_win_pix <= wval;
         if (hit(wr_addr, nv_idx, vcw_pkg::ADDR_WIN_LIN, 3'h4)) reg_win_lin <= wval;
         if (hit(wr_addr, nv_idx, vcw_pkg::ADDR_ROI_PIX, 3'h5)) reg_roi_pix <= wval;
         if (hit(wr_addr, nv_idx, vcw_pkg::ADDR_ROI_LIN, 3'h6)) reg_roi_lin <= wval;
         if (hit(wr_addr, nv_idx, vcw_pkg::ADDR_DECIM, 3'h7)) reg_decim <= wval;
      end
   end

   // Read mux
   wire [31:0] status_word = {16'h0000, done_cnt[12:0], 3'(state)};
   wire [31:0] rd_mux =
      rd_addr == vcw_pkg::ADDR_CTRL ? reg_ctrl :
      rd_addr == vcw_pkg::ADDR_EXTERNAL_TRIGGER_LINE ? reg_external_trigger_line :
      rd_addr == vcw_pkg::ADDR_COUNT ? reg_count :
      rd_addr == vcw_pkg::ADDR_WIN_PIX ? reg_win_pix :
      rd_addr == vcw_pkg::ADDR_WIN_LIN ? reg_win_lin :
      rd_addr == vcw_pkg::ADDR_ROI_PIX ? reg_roi_pix :
      rd_addr == vcw_pkg::ADDR_ROI_LIN ? reg_roi_lin :
      rd_addr == vcw_pkg::ADDR_DECIM ? reg_decim :
      rd_addr == vcw_pkg::ADDR_STATUS ? status_word : 32'h0000_0000;
   assign hrdata = rd_pend ? rd_mux : 32'h0000_0000;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign capture_busy = started;
endmodule
`default_nettype wire

// ---- rtl/vcw_pkg.sv ----
// Package with register map, field positions and reset values of the capture window control
// Behaviour
// - Software start captures fixed field/frame count, stops
// - Trigger start on selected external edge
// - Frame mode may start on odd or even
// - Pixel window start and count from line enable
// - Line window start and count from frame enable
// - Nested region of interest pixel and line ranges
// - ROI off forwards window, on forwards ROI
// - Horizontal decimation by one, two, four, eight
// - Vertical decimation by one, two, four, eight
// - Decimation and ROI work together
// - Trigger line drivable as static output level
// - Trigger line carries selected status event, polarity
// - Registers loaded from nonvolatile storage at power-up
`default_nettype none
package vcw_pkg;
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_EXTERNAL_TRIGGER_LINE = 8'h04;
   localparam logic [7:0] ADDR_COUNT = 8'h08;
   localparam logic [7:0] ADDR_WIN_PIX = 8'h0C;
   localparam logic [7:0] ADDR_WIN_LIN = 8'h10;
   localparam logic [7:0] ADDR_ROI_PIX = 8'h14;
   localparam logic [7:0] ADDR_ROI_LIN = 8'h18;
   localparam logic [7:0] ADDR_DECIM = 8'h1C;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_NV_ADDR = 8'h24;
   localparam logic [7:0] ADDR_NV_DATA = 8'h28;
   // Control register fields
   localparam int CTRL_START = 0;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_EXTERNAL_TRIGGER_LINE_EN = 2;
   localparam int CTRL_FRAME_MODE = 3;
   localparam int CTRL_FIELD_SEL_EN = 4;
   localparam int CTRL_FIELD_ODD = 5;
   localparam int CTRL_ROI_EN = 6;
   // Trigger register fields
   localparam int EXTERNAL_TRIGGER_LINE_EDGE_FALL = 0;
   localparam int EXTERNAL_TRIGGER_LINE_DRIVE_EN = 1;
   localparam int EXTERNAL_TRIGGER_LINE_LEVEL = 2;
   localparam int EXTERNAL_TRIGGER_LINE_EVENT_EN = 3;
   localparam int EXTERNAL_TRIGGER_LINE_INVERT = 4;
   localparam int EXTERNAL_TRIGGER_LINE_EVENT_LSB = 8;
   // Range packing: start in low half, count in high half
   localparam int RANGE_W = 12;
   localparam int HOR_DEC_LSB = 0;
   localparam int VER_DEC_LSB = 4;
   // Reset values used before the configuration load
   localparam logic [31:0] RST_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_EXTERNAL_TRIGGER_LINE = 32'h0000_0000;
   localparam logic [31:0] RST_COUNT = 32'h0000_0001;
   localparam logic [31:0] RST_RANGE = 32'h0FFF_0000;
   localparam logic [31:0] RST_DECIM = 32'h0000_0000;
   localparam int NV_WORDS = 8;
   localparam int NV_AW = 3;
   typedef enum logic [2:0] {VCW_LOAD, VCW_IDLE, VCW_ARMED, VCW_WAIT_FIELD, VCW_RUN}
      vcw_state_t;
endpackage
`default_nettype wire

// ---- rtl/vcw_axis_sel.sv ----
// One axis of window, region of interest and decimation selection
`default_nettype none
module vcw_axis_sel (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic restart,
   input wire logic step,
   input wire logic [31:0] win_range,
   input wire logic [31:0] roi_range,
   input wire logic roi_en,
   input wire logic [1:0] decim,
   output logic keep
);
   logic [11:0] pos;
   logic [11:0] next_pos;
   logic [11:0] win_pos;
   logic [11:0] rel;
   wire [11:0] w_start = win_range[11:0];
   wire [11:0] w_cnt = win_range[27:16];
   wire [11:0] r_start = roi_range[11:0];
   wire [11:0] r_cnt = roi_range[27:16];
   wire [12:0] w_end = {1'b0, w_start} + {1'b0, w_cnt};
   wire [12:0] r_end = {1'b0, r_start} + {1'b0, r_cnt};
   // Index of the current sample, so the sample at the enable edge is index 0
   assign next_pos = restart ? 12'h000 : (step && pos != 12'hFFF) ? pos + 12'h001 : pos;
   wire in_win = (next_pos >= w_start) && ({1'b0, next_pos} < w_end);
   assign win_pos = next_pos - w_start;
   wire in_roi = (win_pos >= r_start) && ({1'b0, win_pos} < r_end);
   wire in_sel = in_win && (!roi_en || in_roi);
   assign rel = roi_en ? (win_pos - r_start) : win_pos;
   wire [11:0] dmask = (12'h001 << decim) - 12'h001;
   wire dec_ok = (rel & dmask) == 12'h000;
   assign keep = in_sel && dec_ok;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pos <= 12'h000;
      end else begin
         pos <= next_pos;
      end
   end
endmodule
`default_nettype wire

// ---- tb/vcw_monitor.sv ----
// Checker on the capture window control ports
`default_nettype none
module vcw_monitor (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic nv_req,
   input wire logic pix_line_en,
   input wire logic pix_frame_en,
   input wire logic [31:0] pix_data,
   input wire logic [31:0] out_data,
   input wire logic out_valid,
   input wire logic out_frame_end
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   chk_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   chk_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   chk_load_once: assert property (!nv_req |=> !nv_req)
      else $error("config load restarted");
   chk_no_pix_load: assert property (out_valid |-> !nv_req && !$past(nv_req))
      else $error("pixel out while loading");
   chk_valid_en: assert property (out_valid |-> $past(pix_line_en) && $past(pix_frame_en))
      else $error("pixel out with enables low");
   chk_data_pass: assert property (out_valid |-> out_data == $past(pix_data))
      else $error("pixel data mismatch");
   chk_end_fall: assert property (out_frame_end |-> $past(pix_frame_en, 2) && !$past(pix_frame_en))
      else $error("frame end not at enable fall");
   chk_end_pulse: assert property (out_frame_end |=> !out_frame_end)
      else $error("frame end longer than one cycle");
endmodule
bind vcw_top vcw_monitor vcw_monitor_inst (.clk(clk), .rst_b(rst_b), .hreadyout(hreadyout),
   .hresp(hresp), .nv_req(nv_req), .pix_line_en(pix_line_en), .pix_frame_en(pix_frame_en),
   .pix_data(pix_data), .out_data(out_data), .out_valid(out_valid),
   .out_frame_end(out_frame_end));
`default_nettype wire

// ---- tb/vcw_video_src.sv ----
// Video decoder model: raster of pixels with line and frame enables
`default_nettype none
module vcw_video_src #(parameter int PIX = 16, parameter int LIN = 6, parameter int HT = 24,
   parameter int VT = 9) (
   input wire logic clk,
   input wire logic rst_b,
   output logic line_en,
   output logic frame_en,
   output logic field_odd,
   output logic [31:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   int h;
   int v;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         h <= 0;
         v <= 0;
         field_odd <= 1'b1;
      end else begin
         h <= (h == HT - 1) ? 0 : h + 1;
         if (h == HT - 1) v <= (v == VT - 1) ? 0 : v + 1;
         if (h == HT - 1 && v == VT - 1) field_odd <= !field_odd;
      end
   end
   assign line_en = rst_b && h < PIX && v < LIN;
   assign frame_en = rst_b && v < LIN;
   // Blanking data changes every cycle so stale values never match
   assign data = line_en ? {16'h0, 8'(v), 8'(h)} : {16'hFFFF, ~8'(v), 8'(h)};
endmodule
`default_nettype wire

// ---- tb/vcw_top_tb.sv ----
// Testbench for the capture window control
`default_nettype none
module vcw_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, hsel, hwrite, nv_valid, trg_drv, ln, fr, fo, out_valid, out_frame_end;
   logic hreadyout, hresp, nv_req, trg_out, trg_oe, busy;
   logic [31:0] haddr, hwdata, hrdata, nv_data, pix_data, out_data, rv;
   logic [1:0] htrans;
   logic [2:0] hsize, nv_addr;
   logic [31:0] got[$], exp[$], nvw[8];
   wire trg_w = trg_oe ? trg_out : trg_drv;
   int errors, total_checks, fends;
   vcw_top vcw_top_inst (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .nv_valid(nv_valid),
      .nv_data(nv_data), .nv_req(nv_req), .nv_addr(nv_addr), .pix_line_en(ln),
      .pix_frame_en(fr), .pix_field_odd(fo), .pix_data(pix_data), .out_data(out_data),
      .out_valid(out_valid), .out_frame_end(out_frame_end), .external_trigger_line_in(trg_w),
      .external_trigger_line_out(trg_out), .external_trigger_line_oe(trg_oe),
      .capture_busy(busy));
   vcw_video_src vcw_video_src_inst (.clk(clk), .rst_b(rst_b), .line_en(ln), .frame_en(fr),
      .field_odd(fo), .data(pix_data));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      nv_valid <= rst_b && nv_req && !nv_valid;
      nv_data <= nvw[nv_addr];
      if (out_valid === 1'b1) got.push_back(out_data);
      if (out_frame_end === 1'b1) fends++;
   end
   task automatic stop_test;
      $display("Checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   task automatic wsig(ref logic s, input logic w, input int lim);
      int n;
      n = 0;
      while (s !== w) begin
         @(posedge clk);
         n++;
         if (n > lim) begin
            errors++;
            stop_test;
         end
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= w;
      @(posedge clk);
      wsig(hreadyout, 1'b1, 50);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      wsig(hreadyout, 1'b1, 50);
      rv = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask
   function automatic bit kp(int i, logic [31:0] w, logic [31:0] r, int d, logic roi);
      int s;
      int b;
      s = w[11:0];
      b = roi ? s + r[11:0] : s;
      kp = i >= s && i < s + w[27:16] && (i - b) % (1 << d) == 0;
      if (roi) kp = kp && i >= b && i < b + r[27:16];
   endfunction
   task automatic cap(input logic [31:0] wp, wl, rp, rl, input int hd, vd, n, input logic roi);
      int f0;
      wr(vcw_pkg::ADDR_WIN_PIX, wp);
      wr(vcw_pkg::ADDR_WIN_LIN, wl);
      wr(vcw_pkg::ADDR_ROI_PIX, rp);
      wr(vcw_pkg::ADDR_ROI_LIN, rl);
      wr(vcw_pkg::ADDR_DECIM, 32'(hd) | (32'(vd) << vcw_pkg::VER_DEC_LSB));
      wr(vcw_pkg::ADDR_COUNT, 32'(n));
      exp.delete();
      for (int f = 0; f < n; f++)
         for (int v = 0; v < 6; v++)
            for (int h = 0; h < 16; h++)
               if (kp(h, wp, rp, hd, roi) && kp(v, wl, rl, vd, roi))
                  exp.push_back({16'h0, 8'(v), 8'(h)});
      got.delete();
      f0 = fends;
      wr(vcw_pkg::ADDR_CTRL, (32'(roi) << vcw_pkg::CTRL_ROI_EN) | 32'h1);
      wsig(busy, 1'b1, 600);
      wsig(busy, 1'b0, 300 * n);
      repeat (2) @(posedge clk);
      chk(32'(got.size()), 32'(exp.size()));
      chk(32'(fends - f0), 32'(n));
      foreach (exp[i]) if (i < got.size()) chk(got[i], exp[i]);
   endtask
   initial begin
      rst_b = 1'b0;
      {hsel, hwrite, trg_drv, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      errors = 0;
      total_checks = 0;
      nvw = '{32'h0, 32'h0, 32'h2, 32'h0010_0000, 32'h0006_0000, 32'h0, 32'h0, 32'h0};
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      wsig(nv_req, 1'b0, 100);
      bus(vcw_pkg::ADDR_COUNT, 1'b0, 32'h0);
      chk(rv, 32'h2);
      bus(vcw_pkg::ADDR_WIN_LIN, 1'b0, 32'h0);
      chk(rv, 32'h0006_0000);
      bus(vcw_pkg::ADDR_STATUS, 1'b0, 32'h0);
      chk(rv, 32'h1);
      bus(8'h3C, 1'b0, 32'h0);
      chk(rv, 32'h0);
      $display("Test load done");
      cap(32'h0008_0002, 32'h0004_0001, 0, 0, 1, 1, 2, 0);
      for (int d = 0; d < 4; d++) cap(32'h0010_0000, 32'h0006_0000, 0, 0, d, 3 - d, 1, 0);
      $display("Test window and decimation done");
      cap(32'h0008_0002, 32'h0004_0001, 32'h0004_0002, 32'h0002_0000, 1, 0, 1, 1);
      $display("Test region of interest done");
      for (int e = 0; e < 2; e++) begin
         trg_drv <= e[0];
         wr(vcw_pkg::ADDR_EXTERNAL_TRIGGER_LINE, 32'(e));
         wr(vcw_pkg::ADDR_CTRL, (32'h1 << vcw_pkg::CTRL_EXTERNAL_TRIGGER_LINE_EN) | 32'h1);
         repeat (300) @(posedge clk);
         chk({31'h0, busy}, 32'h0);
         trg_drv <= !e[0];
         wsig(busy, 1'b1, 500);
         wsig(busy, 1'b0, 1000);
      end
      $display("Test trigger start done");
      for (int o = 0; o < 2; o++) begin
         wr(vcw_pkg::ADDR_CTRL, (32'h1 << vcw_pkg::CTRL_FRAME_MODE) | 32'h1 | (32'(o) <<
            vcw_pkg::CTRL_FIELD_ODD) | (32'h1 << vcw_pkg::CTRL_FIELD_SEL_EN));
         wsig(out_valid, 1'b1, 1000);
         chk({31'h0, fo}, 32'(o));
         wsig(busy, 1'b0, 1000);
      end
      $display("Test field select done");
      wr(vcw_pkg::ADDR_EXTERNAL_TRIGGER_LINE, 32'h6);
      repeat (3) @(posedge clk);
      chk({30'h0, trg_oe, trg_out}, 32'h3);
      wr(vcw_pkg::ADDR_EXTERNAL_TRIGGER_LINE, 32'h2);
      repeat (3) @(posedge clk);
      chk({30'h0, trg_oe, trg_out}, 32'h2);
      wr(vcw_pkg::ADDR_EXTERNAL_TRIGGER_LINE, 32'h0E);
      repeat (3) @(posedge clk);
      chk({30'h0, trg_oe, trg_out}, 32'h2);
      wr(vcw_pkg::ADDR_EXTERNAL_TRIGGER_LINE, 32'h1A);
      repeat (3) @(posedge clk);
      chk({30'h0, trg_oe, trg_out}, 32'h3);
      wr(vcw_pkg::ADDR_CTRL, 32'h1);
      wsig(busy, 1'b1, 600);
      repeat (3) @(posedge clk);
      chk({30'h0, trg_oe, trg_out}, 32'h2);
      wr(vcw_pkg::ADDR_CTRL, 32'h2);
      repeat (2) @(posedge clk);
      chk({31'h0, busy}, 32'h0);
      $display("Test trigger drive done");
      stop_test;
   end
endmodule
`default_nettype wire
